//--- design/ers_stats_regs.vh
// register offsets, field positions, reset values and timing for ers_stats
`ifndef ERS_STATS_REGS_VH
`define ERS_STATS_REGS_VH

`define ERS_ADDR_W 8
`define ERS_DATA_W 32
`define ERS_ZERO32 32'h0000_0000

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ERS_OFS_CFG 8'h00
`define ERS_OFS_INT_STATUS 8'h04
`define ERS_OFS_INT_MASK 8'h08
`define ERS_OFS_CNT_BASE 8'h0C
`define ERS_OFS_CNT_LAST 8'h28

// ----------------------------------------------------------------
// counter indexes (also interrupt status bit positions)
// ----------------------------------------------------------------
`define ERS_NUM_CNT 8
`define ERS_IDX_NO_BUFFER 0
`define ERS_IDX_DMA_OVERRUN 1
`define ERS_IDX_SYMBOL 2
`define ERS_IDX_TOO_LONG 3
`define ERS_IDX_JABBER 4
`define ERS_IDX_SHORT 5
`define ERS_IDX_COL_TEST 6
`define ERS_IDX_LEN_MISMATCH 7

// ----------------------------------------------------------------
// counter field widths
// ----------------------------------------------------------------
`define ERS_WIDE_CNT_W 16
`define ERS_NARROW_CNT_W 8

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define ERS_CFG_SPEED100_BIT 0
`define ERS_CFG_HALF_DUPLEX_BIT 4
`define ERS_CFG_BIG_FRAME_BIT 8
`define ERS_CFG_LEN_CHECK_BIT 16
`define ERS_CFG_MASK 32'h0001_0111
`define ERS_CFG_RESET 32'h0000_0000
`define ERS_INT_MASK_RESET 8'h00
`define ERS_INT_STATUS_RESET 8'h00

// ----------------------------------------------------------------
// frame length limits (bytes)
// ----------------------------------------------------------------
`define ERS_LEN_W 12
`define ERS_MIN_LEN 12'h040
`define ERS_MAX_LEN 12'h5EE
`define ERS_MAX_LEN_BIG 12'h600
`define ERS_HDR_FCS_LEN 12'h012
`define ERS_TYPE_MIN 16'h0600

// ----------------------------------------------------------------
// collision test window: 96 bit times
// ----------------------------------------------------------------
`define ERS_CLK_PERIOD_NS 50
`define ERS_SQE_WIN_10M_NS 9600
`define ERS_SQE_WIN_100M_NS 960
// window in clock cycles, rounded down, sized to the 8-bit window count
`define ERS_SQE_CYC_10M 8'hC0
`define ERS_SQE_CYC_100M 8'h13
`define ERS_SQE_CNT_W 8

`endif

//--- design/ers_counter.v
// one software-loadable statistics counter
`timescale 1ns/10ps
module ers_counter #(
  parameter WIDTH = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_inc,
  input wire i_load,
  input wire [WIDTH-1:0] i_load_val,
  output wire [WIDTH-1:0] o_count
);

  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] count_next;

  // a write in the same cycle as an event keeps the event: load plus one
  always @* begin
    count_next = count_reg;
    if (i_load) begin
      count_next = i_load_val;
    end
    if (i_inc) begin
      count_next = count_next + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule // ers_counter

//--- design/ers_stats.v
// receive error and collision test statistics counters of a 10/100 mac
//
// Functional notes
// (R01) a 16-bit counter counts matched frames lost for want of a buffer.
// (R02) an 8-bit counter counts matched frames lost to a dma overrun.
// (R03) an 8-bit counter counts frames during which rx_er was ever high.
// (R04) symbol errors in legal-length frames count as fcs or alignment errors, or as jabber if long.
// (R05) the longest legal frame is 1518 bytes, 1536 with config bit 8 set.
// (R06) an 8-bit count of too-long frames without crc, align or symbol error.
// (R07) an 8-bit count of too-long frames with a crc, align or symbol error.
// (R08) an 8-bit count of frames under 64 bytes with none of those errors.
// (R09) half duplex: an 8-bit count of col absent 96 bit times after tx_en.
// (R10) an 8-bit count of frames measured shorter than their length field.
// (R11) length field checking runs only while config bit 16 is set.
// (R12) type values from 0x0600 and too-long frames are never a mismatch.
// (R13) counters reset to zero and a software write loads the written value.
`timescale 1ns/10ps
`include "ers_stats_regs.vh"
module ers_stats (
  input wire I_CORE_CLK,
  input wire I_NRST,
  // register port
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [31:0] O_RDATA,
  // phy side
  input wire I_RX_DV,
  input wire I_RX_ER,
  input wire I_TX_EN,
  input wire I_COL,
  // per-frame receive status from the mac
  input wire I_RX_FRAME_DONE,
  input wire [11:0] I_RX_FRAME_LEN,
  input wire [15:0] I_RX_LEN_TYPE,
  input wire I_RX_ADDR_MATCH,
  input wire I_RX_NO_BUFFER,
  input wire I_RX_OVERRUN,
  input wire I_RX_CRC_ERR,
  input wire I_RX_ODD_BITS,
  // events toward the fcs and alignment counters of the mac, and the interrupt request
  output wire O_FCS_ERR_EVENT,
  output wire O_ALIGN_ERR_EVENT,
  output wire O_IRQ
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] cfg_reg;
  reg [7:0] int_status_reg;
  reg [7:0] int_status_next;
  reg [7:0] int_mask_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg sym_seen_reg;
  reg [7:0] event_reg;
  reg [7:0] event_next;
  reg fcs_event_reg;
  reg align_event_reg;
  reg tx_en_d_reg;
  reg sqe_state_reg;
  reg sqe_state_next;
  reg [7:0] sqe_cnt_reg;
  reg [7:0] sqe_cnt_next;
  reg sqe_fail_reg;
  reg sqe_fail_next;

  wire [15:0] count_word [0:7];
  wire [7:0] cnt_load;
  wire speed100;
  wire half_duplex;
  wire big_frame;
  wire len_check;
  wire [11:0] max_len;
  wire [11:0] len_field;
  wire [11:0] payload_len;
  wire sym_err;
  wire err_any;
  wire too_long;
  wire too_short;
  wire is_length_field;
  wire [7:0] sqe_window;
  wire cnt_hit;
  wire [7:0] cnt_ofs;
  wire [2:0] cnt_idx;
  wire legal_len;
  wire fcs_event_next;
  wire align_event_next;
  wire tx_en_fall;
  wire wr_cfg;
  wire wr_int_status;
  wire wr_int_mask;

  localparam SQE_IDLE = 1'b0;
  localparam SQE_ARMED = 1'b1;

  assign speed100 = cfg_reg[`ERS_CFG_SPEED100_BIT];
  assign half_duplex = cfg_reg[`ERS_CFG_HALF_DUPLEX_BIT];
  assign big_frame = cfg_reg[`ERS_CFG_BIG_FRAME_BIT];
  assign len_check = cfg_reg[`ERS_CFG_LEN_CHECK_BIT];

  // ----------------------------------------------------------------
  // frame classification
  // ----------------------------------------------------------------
  assign max_len = big_frame ? `ERS_MAX_LEN_BIG : `ERS_MAX_LEN; // (R05)

  // rx_er seen on the closing cycle of a frame still counts
  assign sym_err = sym_seen_reg | (I_RX_DV & I_RX_ER); // (R03)
  assign err_any = I_RX_CRC_ERR | I_RX_ODD_BITS | sym_err;
  assign too_long = I_RX_FRAME_LEN > max_len; // (R05)
  assign too_short = I_RX_FRAME_LEN < `ERS_MIN_LEN;

  // measured length is the data field: frame less header and fcs
  assign payload_len = (I_RX_FRAME_LEN > `ERS_HDR_FCS_LEN) ?
                       (I_RX_FRAME_LEN - `ERS_HDR_FCS_LEN) : 12'h000;
  assign is_length_field = I_RX_LEN_TYPE < `ERS_TYPE_MIN; // (R12)
  // length field already known below 0x0600, so 12 bits hold it
  assign len_field = I_RX_LEN_TYPE[11:0];

  // latch rx_er across the frame; the frame done strobe clears it
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sym_seen_reg <= 1'b0;
    end else if (I_RX_FRAME_DONE) begin
      sym_seen_reg <= 1'b0;
    end else if (I_RX_DV & I_RX_ER) begin
      sym_seen_reg <= 1'b1; // (R03)
    end
  end

  always @* begin
    event_next = 8'h00;
    if (I_RX_FRAME_DONE) begin
      event_next[`ERS_IDX_NO_BUFFER] =
        I_RX_ADDR_MATCH & I_RX_NO_BUFFER; // (R01)
      event_next[`ERS_IDX_DMA_OVERRUN] =
        I_RX_ADDR_MATCH & I_RX_OVERRUN; // (R02)
      event_next[`ERS_IDX_SYMBOL] = sym_err; // (R03)
      event_next[`ERS_IDX_TOO_LONG] = too_long & ~err_any; // (R06)
      event_next[`ERS_IDX_JABBER] = too_long & err_any; // (R07) (R04)
      event_next[`ERS_IDX_SHORT] = too_short & ~err_any; // (R08)
      event_next[`ERS_IDX_LEN_MISMATCH] = len_check & // (R11)
        is_length_field & ~too_long & // (R12)
        (payload_len < len_field); // (R10)
    end
    event_next[`ERS_IDX_COL_TEST] = sqe_fail_reg; // (R09)
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      event_reg <= 8'h00;
    end else begin
      event_reg <= event_next;
    end
  end

  // legal-length symbol errors also feed the fcs or alignment count
  assign legal_len = ~too_long & ~too_short;
  assign fcs_event_next = I_RX_FRAME_DONE & sym_err & legal_len &
                          ~I_RX_ODD_BITS; // (R04)
  assign align_event_next = I_RX_FRAME_DONE & sym_err & legal_len &
                            I_RX_ODD_BITS; // (R04)

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      fcs_event_reg <= 1'b0;
      align_event_reg <= 1'b0;
    end else begin
      fcs_event_reg <= fcs_event_next;
      align_event_reg <= align_event_next;
    end
  end

  assign O_FCS_ERR_EVENT = fcs_event_reg;
  assign O_ALIGN_ERR_EVENT = align_event_reg;

  // ----------------------------------------------------------------
  // collision (sqe) test after transmit
  // ----------------------------------------------------------------
  // the window is rounded down so a late col is never wrongly accepted
  assign sqe_window = speed100 ? `ERS_SQE_CYC_100M : `ERS_SQE_CYC_10M;
  assign tx_en_fall = tx_en_d_reg & ~I_TX_EN;

  // a new falling edge while armed restarts the window
  always @* begin
    sqe_state_next = sqe_state_reg;
    sqe_cnt_next = sqe_cnt_reg;
    sqe_fail_next = 1'b0;
    case (sqe_state_reg)
      SQE_IDLE: begin
        if (tx_en_fall & half_duplex) begin
          sqe_state_next = SQE_ARMED; // (R09)
          sqe_cnt_next = 8'h00;
        end
      end
      SQE_ARMED: begin
        if (tx_en_fall & half_duplex) begin
          sqe_cnt_next = 8'h00;
        end else if (I_COL | I_TX_EN | ~half_duplex) begin
          sqe_state_next = SQE_IDLE;
        end else if (sqe_cnt_reg == sqe_window - 8'h01) begin
          sqe_state_next = SQE_IDLE;
          sqe_fail_next = 1'b1; // (R09)
        end else begin
          sqe_cnt_next = sqe_cnt_reg + 8'h01;
        end
      end
      default: begin
        sqe_state_next = SQE_IDLE;
      end
    endcase
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_en_d_reg <= 1'b0;
      sqe_state_reg <= SQE_IDLE;
      sqe_cnt_reg <= 8'h00;
      sqe_fail_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= I_TX_EN;
      sqe_state_reg <= sqe_state_next;
      sqe_cnt_reg <= sqe_cnt_next;
      sqe_fail_reg <= sqe_fail_next;
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  assign cnt_hit = (I_ADDR >= `ERS_OFS_CNT_BASE) &&
                   (I_ADDR <= `ERS_OFS_CNT_LAST) && (I_ADDR[1:0] == 2'b00);
  assign cnt_ofs = I_ADDR - `ERS_OFS_CNT_BASE;
  assign cnt_idx = cnt_ofs[4:2];

  genvar gi;
  generate
    for (gi = 0; gi < `ERS_NUM_CNT; gi = gi + 1) begin : g_cnt
      localparam CW = (gi == `ERS_IDX_NO_BUFFER) ?
                      `ERS_WIDE_CNT_W : `ERS_NARROW_CNT_W;
      wire [CW-1:0] cnt_val;
      assign cnt_load[gi] = I_WR & cnt_hit & (cnt_idx == gi); // (R13)
      ers_counter #(
        .WIDTH(CW)
      ) u_cnt (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_inc(event_reg[gi]), // (R01) (R02) (R03) (R06) (R07) (R08)
        .i_load(cnt_load[gi]), // (R13)
        .i_load_val(I_WDATA[CW-1:0]),
        .o_count(cnt_val)
      );
      if (CW < `ERS_WIDE_CNT_W) begin : g_pad
        assign count_word[gi] = {{(`ERS_WIDE_CNT_W-CW){1'b0}}, cnt_val};
      end else begin : g_full
        assign count_word[gi] = cnt_val;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration, interrupt status and mask
  // ----------------------------------------------------------------
  assign wr_cfg = I_WR && (I_ADDR == `ERS_OFS_CFG);
  assign wr_int_status = I_WR && (I_ADDR == `ERS_OFS_INT_STATUS);
  assign wr_int_mask = I_WR && (I_ADDR == `ERS_OFS_INT_MASK);

  always @* begin
    int_status_next = int_status_reg;
    if (wr_int_status) begin
      int_status_next = int_status_next & ~I_WDATA[7:0];
    end
    // set wins over a clear in the same cycle
    int_status_next = int_status_next | event_reg;
  end

  // unused config bits are dropped so they always read back as zero
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_reg <= `ERS_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= I_WDATA & `ERS_CFG_MASK; // (R05) (R11)
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      int_status_reg <= `ERS_INT_STATUS_RESET;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      int_mask_reg <= `ERS_INT_MASK_RESET;
    end else if (wr_int_mask) begin
      int_mask_reg <= I_WDATA[7:0];
    end
  end

  assign O_IRQ = |(int_status_reg & int_mask_reg);

  // ----------------------------------------------------------------
  // read port: data stand the cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  // a counter read shows the value before any same-cycle increment
  always @* begin
    rdata_next = `ERS_ZERO32;
    if (I_RD) begin
      case (I_ADDR)
        `ERS_OFS_CFG: begin
          rdata_next = cfg_reg;
        end
        `ERS_OFS_INT_STATUS: begin
          rdata_next = {24'h00_0000, int_status_reg};
        end
        `ERS_OFS_INT_MASK: begin
          rdata_next = {24'h00_0000, int_mask_reg};
        end
        default: begin
          if (cnt_hit) begin
            rdata_next = {16'h0000, count_word[cnt_idx]};
          end
        end
      endcase
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_reg <= `ERS_ZERO32;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;

endmodule // ers_stats

//--- verification/ers_stats_chk.sv
// port assertions for the receive error statistics block
`timescale 1ns/10ps
module ers_stats_chk (
  input wire I_CORE_CLK,
  input wire I_NRST,
  input wire [7:0] I_ADDR,
  input wire I_RD,
  input wire [31:0] O_RDATA,
  input wire I_RX_FRAME_DONE,
  input wire [11:0] I_RX_FRAME_LEN,
  input wire I_RX_ODD_BITS,
  input wire O_FCS_ERR_EVENT,
  input wire O_ALIGN_ERR_EVENT
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_rd_narrow;
    I_RD && I_ADDR >= 8'h10 && I_ADDR <= 8'h28;
  endsequence
  sequence s_done_bad_len;
    I_RX_FRAME_DONE && (I_RX_FRAME_LEN > 12'h600 || I_RX_FRAME_LEN < 12'h040);
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_idle_rdata:
    assert property (!I_RD |=> O_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_wide_cnt:
    assert property (I_RD && I_ADDR == 8'h0C |=> O_RDATA[31:16] == 16'h0000)
    else $error("wide counter shows upper bits");
  a_narrow_cnt:
    assert property (s_rd_narrow |=> O_RDATA[31:8] == 24'h00_0000)
    else $error("narrow counter shows upper bits");
  a_cfg_bits:
    assert property (I_RD && I_ADDR == 8'h00 |=> !(|(O_RDATA & 32'hFFFE_FEEE)))
    else $error("config shows undefined bits");
  a_unmapped_zero:
    assert property (I_RD && I_ADDR > 8'h28 |=> O_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_bad_len_quiet:
    assert property (s_done_bad_len |=> !O_FCS_ERR_EVENT && !O_ALIGN_ERR_EVENT)
    else $error("fcs or alignment event for illegal length");
  a_fcs_cause:
    assert property (O_FCS_ERR_EVENT |-> $past(I_RX_FRAME_DONE)
      && !$past(I_RX_ODD_BITS))
    else $error("fcs event without an integral frame end");
  a_align_cause:
    assert property (O_ALIGN_ERR_EVENT |-> $past(I_RX_FRAME_DONE)
      && $past(I_RX_ODD_BITS))
    else $error("alignment event without an odd frame end");
endmodule // ers_stats_chk

//--- verification/ers_phy_model.sv
// phy model: frames with optional rx_er, sqe answer on col
`timescale 1ns/10ps
module ers_phy_model (
  input wire i_clk,
  input wire i_send,
  input wire i_er,
  input wire i_tx_en,
  input wire [7:0] i_sqe_dly,
  output wire o_rx_dv,
  output wire o_rx_er,
  output wire o_col,
  output wire o_done
);
  reg [3:0] rx_cnt_reg = 4'h0;
  reg [7:0] col_cnt_reg = 8'h00;
  reg er_reg = 1'b0;
  reg tx_en_d_reg = 1'b0;
  assign o_rx_dv = rx_cnt_reg != 4'h0;
  // rx_er left high between frames: only rx_er beside rx_dv may count
  assign o_rx_er = o_rx_dv ? (er_reg && rx_cnt_reg == 4'h3) : 1'b1;
  assign o_done = rx_cnt_reg == 4'h1;
  // a delay of zero means the collision test signal never comes
  assign o_col = col_cnt_reg == 8'h01;
  always @(posedge i_clk) begin
    tx_en_d_reg <= i_tx_en;
    if (i_send) begin
      rx_cnt_reg <= 4'h6;
      er_reg <= i_er;
    end else if (o_rx_dv) begin
      rx_cnt_reg <= rx_cnt_reg - 4'h1;
    end
    if (tx_en_d_reg && !i_tx_en) begin
      col_cnt_reg <= i_sqe_dly;
    end else if (col_cnt_reg != 8'h00) begin
      col_cnt_reg <= col_cnt_reg - 8'h01;
    end
  end
endmodule // ers_phy_model

//--- verification/tb.sv
// self-checking bench for the receive error statistics block
`timescale 1ns/10ps
module tb;
  reg clk, nrst, wr, rd, tx_en, send, er;
  reg [7:0] addr, dly;
  reg [31:0] wdata, d;
  reg [11:0] len;
  reg [15:0] lt;
  reg [4:0] fl;
  wire dv, rx_er, col, done, fcs, aln, irq;
  wire [31:0] rdata;
  reg [31:0] exp_c [0:7];
  integer miscompares, n_tests, n_fcs, n_aln, i;
  ers_stats i_dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_DV(dv),
    .I_RX_ER(rx_er), .I_TX_EN(tx_en), .I_COL(col), .I_RX_FRAME_DONE(done),
    .I_RX_FRAME_LEN(len), .I_RX_LEN_TYPE(lt), .I_RX_ADDR_MATCH(fl[4]),
    .I_RX_NO_BUFFER(fl[3]), .I_RX_OVERRUN(fl[2]), .I_RX_CRC_ERR(fl[1]),
    .I_RX_ODD_BITS(fl[0]), .O_FCS_ERR_EVENT(fcs), .O_ALIGN_ERR_EVENT(aln),
    .O_IRQ(irq));
  ers_phy_model i_phy (.i_clk(clk), .i_send(send), .i_er(er),
    .i_tx_en(tx_en), .i_sqe_dly(dly), .o_rx_dv(dv), .o_rx_er(rx_er),
    .o_col(col), .o_done(done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    n_fcs = n_fcs + (fcs === 1'b1);
    n_aln = n_aln + (aln === 1'b1);
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
    end
  endtask
  task chk_all;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rd_reg(8'h0C + 8'h04 * i[7:0]);
        chk(d, exp_c[i]);
      end
    end
  endtask
  // status held for the whole frame; b marks the counters that must move
  task frame(input [11:0] l, input [15:0] t, input [4:0] f, input e,
    input [7:0] b);
    begin
      @(posedge clk);
      len <= l;
      lt <= t;
      fl <= f;
      er <= e;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (8) @(posedge clk);
      for (i = 0; i < 8; i = i + 1)
        exp_c[i] = exp_c[i] + {31'h0000_0000, b[i]};
    end
  endtask
  // the wait covers the slow window plus the two-cycle count delay
  task tx(input [7:0] dl, input b);
    begin
      @(posedge clk);
      tx_en <= 1'b1;
      dly <= dl;
      repeat (10) @(posedge clk);
      tx_en <= 1'b0;
      repeat (230) @(posedge clk);
      exp_c[6] = exp_c[6] + {31'h0000_0000, b};
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      chk_all;
      for (i = 0; i < 8; i = i + 1) begin
        wr_reg(8'h0C + 8'h04 * i[7:0], 32'hFFFF_FF5A);
        exp_c[i] = (i == 0) ? 32'h0000_FF5A : 32'h0000_005A;
      end
      chk_all;
      rd_reg(8'h2C);
      chk(d, 32'h0000_0000);
      wr_reg(8'h00, 32'hFFFF_FFFF);
      rd_reg(8'h00);
      chk(d, 32'h0001_0111);
      wr_reg(8'h00, 32'h0000_0000);
      $display("register test done");
    end
  endtask
  task t_rx;
    begin
      frame(12'h064, 16'h0000, 5'h18, 1'b0, 8'h01);
      frame(12'h064, 16'h0000, 5'h14, 1'b0, 8'h02);
      frame(12'h064, 16'h0000, 5'h00, 1'b1, 8'h04);
      frame(12'h064, 16'h0000, 5'h01, 1'b1, 8'h04);
      frame(12'h640, 16'h0000, 5'h00, 1'b1, 8'h14);
      frame(12'h5EF, 16'h0000, 5'h00, 1'b0, 8'h08);
      frame(12'h5EE, 16'h0000, 5'h00, 1'b0, 8'h00);
      frame(12'h5EF, 16'h0000, 5'h02, 1'b0, 8'h10);
      frame(12'h03F, 16'h0000, 5'h00, 1'b0, 8'h20);
      frame(12'h03F, 16'h0000, 5'h02, 1'b0, 8'h00);
      frame(12'h040, 16'h0000, 5'h00, 1'b0, 8'h00);
      wr_reg(8'h00, 32'h0000_0100);
      frame(12'h600, 16'h0000, 5'h00, 1'b0, 8'h00);
      frame(12'h601, 16'h0000, 5'h00, 1'b0, 8'h08);
      chk_all;
      chk(n_fcs, 32'h0000_0001);
      chk(n_aln, 32'h0000_0001);
      $display("receive test done");
    end
  endtask
  task t_len;
    begin
      wr_reg(8'h00, 32'h0001_0000);
      frame(12'h064, 16'h0053, 5'h00, 1'b0, 8'h80);
      frame(12'h064, 16'h0052, 5'h00, 1'b0, 8'h00);
      frame(12'h064, 16'h05FF, 5'h00, 1'b0, 8'h80);
      frame(12'h064, 16'h0600, 5'h00, 1'b0, 8'h00);
      frame(12'h5EF, 16'h05FF, 5'h00, 1'b0, 8'h08);
      wr_reg(8'h00, 32'h0000_0000);
      frame(12'h064, 16'h0053, 5'h00, 1'b0, 8'h00);
      chk_all;
      $display("length test done");
    end
  endtask
  task t_sqe;
    begin
      wr_reg(8'h00, 32'h0000_0011);
      tx(8'h05, 1'b0);
      tx(8'h00, 1'b1);
      tx(8'h1E, 1'b1);
      tx(8'h13, 1'b0);
      tx(8'h14, 1'b1);
      wr_reg(8'h00, 32'h0000_0010);
      tx(8'h64, 1'b0);
      tx(8'hC0, 1'b0);
      tx(8'hC1, 1'b1);
      tx(8'h00, 1'b1);
      wr_reg(8'h00, 32'h0000_0001);
      tx(8'h00, 1'b0);
      chk_all;
      $display("collision test done");
    end
  endtask
  task t_irq;
    begin
      wr_reg(8'h04, 32'h0000_00FF);
      wr_reg(8'h08, 32'h0000_0008);
      rd_reg(8'h08);
      chk(d, 32'h0000_0008);
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      frame(12'h5EF, 16'h0000, 5'h00, 1'b0, 8'h08);
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr_reg(8'h04, 32'h0000_0008);
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr_reg(8'h08, 32'h0000_0000);
      frame(12'h5EF, 16'h0000, 5'h00, 1'b0, 8'h08);
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      rd_reg(8'h04);
      chk(d, 32'h0000_0008);
      $display("interrupt test done");
    end
  endtask
  initial begin
    {nrst, wr, rd, tx_en, send, er} = 6'h00;
    {addr, dly, wdata, len, lt, fl} = 81'h0;
    {miscompares, n_tests, n_fcs, n_aln} = 128'h0;
    for (i = 0; i < 8; i = i + 1)
      exp_c[i] = 32'h0000_0000;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_rx;
    t_len;
    t_sqe;
    t_irq;
    test_done;
  end
endmodule // tb
bind ers_stats ers_stats_chk i_chk (.I_CORE_CLK(I_CORE_CLK),
  .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_RX_FRAME_DONE(I_RX_FRAME_DONE), .I_RX_FRAME_LEN(I_RX_FRAME_LEN),
  .I_RX_ODD_BITS(I_RX_ODD_BITS), .O_FCS_ERR_EVENT(O_FCS_ERR_EVENT),
  .O_ALIGN_ERR_EVENT(O_ALIGN_ERR_EVENT));
